// ===== hw/deser_ctrl_pkg.sv
// Package for the deserializer control and status block.
// Assumes one 8-bit register port and a recovered link clock.
package deser_ctrl_pkg;
   // Register offsets
   localparam logic [7:0] OUTPUT_CONTROL_ADDR = 8'h02;
   localparam logic [7:0] PIN0_CONFIG_ADDR = 8'h1d;
   localparam logic [7:0] PIN1_PIN2_CONFIG_ADDR = 8'h1e;
   localparam logic [7:0] PIN3_CONFIG_ADDR = 8'h1f;
   localparam logic [7:0] PORT_SELECT_ADDR = 8'h34;
   // Field positions
   localparam int OC_OUT_EN_BIT = 7;
   localparam int OC_OSC_EN_BIT = 5;
   localparam int OC_SLEEP_SEL_BIT = 4;
   localparam int FIRST_PORT_BIT = 0;
   localparam int SECOND_PORT_BIT = 1;
   // Reset values
   localparam logic [7:0] OUTPUT_CONTROL_RESET = 8'h90;
   localparam logic [7:0] PIN_CONFIG_RESET = 8'h00;
   localparam logic [1:0] PORT_SELECT_RESET = 2'h1;
   // Pin modes
   localparam logic [3:0] PIN_MODE_FWD_OUT = 4'h5;
   localparam logic [3:0] PIN_MODE_BC_IN = 4'h3;
   // Back channel timing
   localparam int LINK_CLK_KHZ = 83333;
   localparam int BC_RATE_LOW_MBPS = 5;
   localparam int BC_RATE_HIGH_MBPS = 20;
   localparam int BC_DIV_LOW = LINK_CLK_KHZ / (BC_RATE_LOW_MBPS * 1000);
   localparam int BC_DIV_HIGH = LINK_CLK_KHZ / (BC_RATE_HIGH_MBPS * 1000);
   localparam int BC_FRAME_BITS = 29;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'hff;

   typedef struct packed {
      logic o;
      logic oe;
   } pin_drive_t;

   typedef struct packed {
      logic [3:0] o;
      logic [3:0] oe;
   } gpio_drive_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] cp;
      logic [3:0] gpio;
      logic irq;
      logic [7:0] crc;
   } bc_frame_t;

   typedef enum logic [1:0] {
      GRP_Z = 2'b00,
      GRP_LOW = 2'b01,
      GRP_VALID = 2'b11
   } grp_state_t;

   typedef enum logic [1:0] {
      CLK_LOW = 2'b00,
      CLK_RECOVERED = 2'b01,
      CLK_OSC = 2'b11
   } clk_mode_t;

   typedef enum logic {
      BC_LOAD = 1'b0,
      BC_SHIFT = 1'b1
   } bc_state_t;
endpackage

// ===== hw/deser_status_port_gpio_ctrl.sv
// Control and status logic of a serial-link video deserializer.
// Assumes link_clk is the recovered clock and rst is a system reset.
// How it works
// - Back channel 5 or 20 Mbps by strap
// - Frame holds control, protection, CRC, four pins
// - Port-select bits steer duplicated registers
// - Read returns selected copy, port 1 wins
// - Write updates every selected port copy
// - Lost input plus enable, sleep select low: oscillator clock
// - Acquiring keeps lock low or floating
// - Completed lock drives lock high if sleep select high
// - Active, enabled, sleep high: all outputs valid
// - Output enable low: sleep select picks states
// - Static input with enable: low or held
// - Power-down low floats all outputs but the interrupt pin
// - Downstream interrupt input is active low
// - Interrupt state forwarded across the link
// - Power-down low drives interrupt pin low
// - Primary pins are forward outputs or back inputs; second-lane pins forward only
// - Mode 0x5 forward output, 0x3 back input
// - Pin fields at pin0_config, pin1_pin2_config, pin3_config
// - Port select picks primary or second-lane pins
// - Second-lane pins only in two-lane mode
// - Colour depth mode comes from the link
`timescale 1ns/1ps
module deser_status_port_gpio_ctrl
   import deser_ctrl_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int LOCK_CYCLES = 64
)(
   // Clocks and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic link_clk,
   // Register port
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Pins and straps
   input wire logic power_down_bar,
   input wire logic back_channel_rate_strap,
   // Link side, on link_clk
   input wire logic serial_active,
   input wire logic two_lane_mode,
   input wire logic fwd_color18,
   input wire logic [3:0] fwd_gpio_first,
   input wire logic [3:0] fwd_gpio_second,
   input wire logic [7:0] bc_ctrl_data,
   input wire logic [7:0] bc_cp_data,
   output logic bc_tx,
   output logic bc_frame_start,
   // Datapath, on clock
   input wire logic [DATA_W-1:0] rx_data,
   input wire logic bist_pass_in,
   // Status and display outputs
   output pin_drive_t lock_pin,
   output pin_drive_t pass_pin,
   output logic [DATA_W-1:0] data_o,
   output logic data_oe,
   output clk_mode_t disp_clk_mode,
   output logic disp_clk_oe,
   output logic color_18bit_mode,
   // General-purpose pins
   input wire logic [3:0] gpio_first_in,
   input wire logic [3:0] gpio_second_in,
   output gpio_drive_t gpio_first_pin,
   output gpio_drive_t gpio_second_pin,
   // Downstream interrupt pin
   input wire logic downstream_irq_in,
   output logic irq_pin_o,
   output logic irq_pin_oe
);
   localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
   // Interrupt pin idles high; reset there, else a false request follows
   localparam logic [9:0] PIN_IDLE = 10'h200;

   // Pin synchronisers: change accepted when stages two and three agree
   logic [9:0] pin_raw;
   logic [9:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_s_reg;
   logic pdb_s, irq_s;
   logic [3:0] gpio_first_s, gpio_second_s;
   assign pin_raw = {downstream_irq_in, gpio_second_in, gpio_first_in,
                     power_down_bar};
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pin_s1_reg <= PIN_IDLE;
         pin_s2_reg <= PIN_IDLE;
         pin_s3_reg <= PIN_IDLE;
         pin_s_reg <= PIN_IDLE;
      end
      else
      begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_s_reg <= (pin_s2_reg & pin_s3_reg) |
                      (pin_s_reg & (pin_s2_reg | pin_s3_reg));
      end
   end
   assign pdb_s = pin_s_reg[0];
   assign gpio_first_s = pin_s_reg[4:1];
   assign gpio_second_s = pin_s_reg[8:5];
   assign irq_s = pin_s_reg[9];

   // Link-to-system level crossings
   logic [10:0] l2s_raw, l2s_1_reg, l2s_2_reg;
   logic locked_link_reg, locked_s, two_lane_s, color18_s;
   logic [3:0] fwd_first_s, fwd_second_s;
   assign l2s_raw = {fwd_gpio_second, fwd_gpio_first, fwd_color18,
                     two_lane_mode, locked_link_reg};
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         l2s_1_reg <= 11'h000;
         l2s_2_reg <= 11'h000;
      end
      else
      begin
         l2s_1_reg <= l2s_raw;
         l2s_2_reg <= l2s_1_reg;
      end
   end
   assign locked_s = l2s_2_reg[0];
   assign two_lane_s = l2s_2_reg[1];
   assign color18_s = l2s_2_reg[2];
   assign fwd_first_s = l2s_2_reg[6:3];
   assign fwd_second_s = l2s_2_reg[10:7];

   // Register file
   logic [7:0] output_control_reg;
   logic [1:0] port_select_reg;
   logic [7:0] cfg_reg [2][3];
   logic is_cfg;
   logic [1:0] cfg_idx;
   logic [7:0] rdata_next;
   assign is_cfg = (reg_addr == PIN0_CONFIG_ADDR) ||
                   (reg_addr == PIN1_PIN2_CONFIG_ADDR) ||
                   (reg_addr == PIN3_CONFIG_ADDR);
   assign cfg_idx = 2'(reg_addr - PIN0_CONFIG_ADDR);

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         output_control_reg <= OUTPUT_CONTROL_RESET;
         port_select_reg <= PORT_SELECT_RESET;
         for (int p = 0; p < 2; p++)
            for (int r = 0; r < 3; r++)
               cfg_reg[p][r] <= PIN_CONFIG_RESET;
      end
      else if (reg_write)
      begin
         if (reg_addr == OUTPUT_CONTROL_ADDR)
            output_control_reg <= reg_wdata;
         if (reg_addr == PORT_SELECT_ADDR)
            port_select_reg <= reg_wdata[1:0];
         if (is_cfg)
            for (int p = 0; p < 2; p++)
               if (port_select_reg[p])
                  cfg_reg[p][cfg_idx] <= reg_wdata;
      end
   end

   // Port 1 copy wins when both select bits are set
   always_comb
   begin
      rdata_next = 8'h00;
      if (reg_addr == OUTPUT_CONTROL_ADDR)
         rdata_next = output_control_reg;
      else if (reg_addr == PORT_SELECT_ADDR)
         rdata_next = {6'h00, port_select_reg};
      else if (is_cfg)
         rdata_next = port_select_reg[SECOND_PORT_BIT] ?
                      cfg_reg[1][cfg_idx] : cfg_reg[0][cfg_idx];
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_read;
         if (reg_read)
            reg_rdata <= rdata_next;
      end
   end

   // Pin mode decode per port
   function automatic logic [3:0] pin_field(input logic [7:0] c [3],
                                            input int pin);
      case (pin)
         0: return c[0][3:0];
         1: return c[1][3:0];
         2: return c[1][7:4];
         default: return c[2][3:0];
      endcase
   endfunction
   logic [3:0] fwd_mask [2];
   logic [3:0] bc_mask [2];
   always_comb
   begin
      for (int p = 0; p < 2; p++)
         for (int i = 0; i < 4; i++)
         begin
            fwd_mask[p][i] = pin_field(cfg_reg[p], i) == PIN_MODE_FWD_OUT;
            bc_mask[p][i] = pin_field(cfg_reg[p], i) == PIN_MODE_BC_IN;
         end
   end

   // Output state matrix
   logic out_en, osc_en, sleep_sel;
   pin_drive_t lock_d, pass_d;
   grp_state_t data_st;
   clk_mode_t clk_d;
   logic clk_oe_d, pass_hold_reg;
   assign out_en = output_control_reg[OC_OUT_EN_BIT];
   assign osc_en = output_control_reg[OC_OSC_EN_BIT];
   assign sleep_sel = output_control_reg[OC_SLEEP_SEL_BIT];
   always_comb
   begin
      lock_d = '{o: 1'b0, oe: 1'b0};
      pass_d = '{o: 1'b0, oe: 1'b0};
      data_st = GRP_Z;
      clk_d = CLK_LOW;
      clk_oe_d = 1'b0;
      if (!pdb_s)
         data_st = GRP_Z;
      else if (!out_en)
      begin
         lock_d = '{o: sleep_sel & locked_s, oe: 1'b1};
         if (!sleep_sel)
         begin
            pass_d.oe = 1'b1;
            data_st = GRP_LOW;
            clk_oe_d = 1'b1;
         end
      end
      else if (!locked_s)
      begin
         lock_d = '{o: 1'b0, oe: 1'b1};
         pass_d = '{o: sleep_sel & pass_hold_reg, oe: 1'b1};
         data_st = GRP_LOW;
         clk_oe_d = 1'b1;
         if (!sleep_sel && osc_en)
            clk_d = CLK_OSC;
      end
      else
      begin
         lock_d = '{o: sleep_sel, oe: 1'b1};
         pass_d = '{o: sleep_sel & bist_pass_in, oe: 1'b1};
         data_st = sleep_sel ? GRP_VALID : GRP_LOW;
         clk_d = sleep_sel ? CLK_RECOVERED : CLK_LOW;
         clk_oe_d = 1'b1;
      end
   end

   // Registered pin drives; second lane floats outside two-lane mode
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lock_pin <= '{o: 1'b0, oe: 1'b0};
         pass_pin <= '{o: 1'b0, oe: 1'b0};
         pass_hold_reg <= 1'b0;
         data_o <= '0;
         data_oe <= 1'b0;
         disp_clk_mode <= CLK_LOW;
         disp_clk_oe <= 1'b0;
         gpio_first_pin <= '{o: 4'h0, oe: 4'h0};
         gpio_second_pin <= '{o: 4'h0, oe: 4'h0};
         irq_pin_o <= 1'b0;
         irq_pin_oe <= 1'b0;
         color_18bit_mode <= 1'b0;
      end
      else
      begin
         lock_pin <= lock_d;
         pass_pin <= pass_d;
         if (data_st == GRP_VALID)
            pass_hold_reg <= bist_pass_in;
         data_o <= (data_st == GRP_VALID) ? rx_data : '0;
         data_oe <= data_st != GRP_Z;
         disp_clk_mode <= clk_d;
         disp_clk_oe <= clk_oe_d;
         gpio_first_pin.oe <= (data_st == GRP_Z) ? 4'h0 :
            (data_st == GRP_LOW) ? 4'hf : fwd_mask[0];
         gpio_first_pin.o <= (data_st == GRP_VALID) ?
            (fwd_first_s & fwd_mask[0]) : 4'h0;
         gpio_second_pin.oe <= (data_st == GRP_Z || !two_lane_s) ? 4'h0 :
            (data_st == GRP_LOW) ? 4'hf : fwd_mask[1];
         gpio_second_pin.o <= (data_st == GRP_VALID && two_lane_s) ?
            (fwd_second_s & fwd_mask[1]) : 4'h0;
         irq_pin_o <= 1'b0;
         irq_pin_oe <= !pdb_s;
         color_18bit_mode <= color18_s;
      end
   end

   // System-to-link crossings of levels
   logic [5:0] s2l_raw, s2l_1_reg, s2l_2_reg;
   logic link_rst;
   logic [1:0] link_rst_reg;
   assign s2l_raw = {~irq_s, gpio_first_s & bc_mask[0], pdb_s};
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
         link_rst_reg <= 2'b11;
      else
         link_rst_reg <= {link_rst_reg[0], 1'b0};
   end
   assign link_rst = link_rst_reg[1];
   always_ff @(posedge link_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         s2l_1_reg <= 6'h00;
         s2l_2_reg <= 6'h00;
      end
      else
      begin
         s2l_1_reg <= s2l_raw;
         s2l_2_reg <= s2l_1_reg;
      end
   end

   // Lock sequence on the recovered clock
   logic [LOCK_W-1:0] lock_cnt_reg;
   always_ff @(posedge link_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         lock_cnt_reg <= '0;
         locked_link_reg <= 1'b0;
      end
      else if (!s2l_2_reg[0] || !serial_active)
      begin
         lock_cnt_reg <= '0;
         locked_link_reg <= 1'b0;
      end
      else if (lock_cnt_reg != LOCK_W'(LOCK_CYCLES))
         lock_cnt_reg <= lock_cnt_reg + 1'b1;
      else
         locked_link_reg <= 1'b1;
   end

   // Rate strap caught once after the link reset lets go
   logic [2:0] strap_reg, strap_fill_reg;
   logic strap_taken_reg, rate_hi_reg;
   always_ff @(posedge link_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         strap_reg <= 3'b000;
         strap_fill_reg <= 3'b000;
         strap_taken_reg <= 1'b0;
         rate_hi_reg <= 1'b0;
      end
      else
      begin
         strap_reg <= {strap_reg[1:0], back_channel_rate_strap};
         strap_fill_reg <= {strap_fill_reg[1:0], 1'b1};
         // Reset zeros in the stages must not pass for a strap level
         if (!strap_taken_reg && strap_fill_reg[2] &&
             strap_reg[1] == strap_reg[2])
         begin
            strap_taken_reg <= 1'b1;
            rate_hi_reg <= strap_reg[2];
         end
      end
   end

   // Back-channel framer
   function automatic logic [7:0] crc8(input logic [20:0] d);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 20; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
      return c;
   endfunction
   bc_frame_t frame;
   bc_state_t bc_state_reg;
   bc_frame_t shift_reg;
   logic [4:0] div_cnt_reg, bit_idx_reg;
   logic bit_tick;
   always_comb
   begin
      frame.ctrl = bc_ctrl_data;
      frame.cp = bc_cp_data;
      frame.gpio = s2l_2_reg[4:1];
      frame.irq = s2l_2_reg[5];
      frame.crc = crc8({bc_ctrl_data, bc_cp_data, s2l_2_reg[4:1],
                        s2l_2_reg[5]});
   end
   assign bit_tick = div_cnt_reg == 5'h00;
   always_ff @(posedge link_clk or posedge link_rst)
   begin
      if (link_rst)
         div_cnt_reg <= 5'h00;
      else if (bit_tick)
         div_cnt_reg <= rate_hi_reg ? 5'(BC_DIV_HIGH - 1) :
                        5'(BC_DIV_LOW - 1);
      else
         div_cnt_reg <= div_cnt_reg - 1'b1;
   end
   always_ff @(posedge link_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         bc_state_reg <= BC_LOAD;
         shift_reg <= '0;
         bit_idx_reg <= 5'h00;
         bc_tx <= 1'b0;
         bc_frame_start <= 1'b0;
      end
      else
      begin
         bc_frame_start <= 1'b0;
         unique case (bc_state_reg)
            BC_LOAD:
            begin
               shift_reg <= frame;
               bit_idx_reg <= 5'(BC_FRAME_BITS - 1);
               bc_frame_start <= 1'b1;
               bc_state_reg <= BC_SHIFT;
            end
            BC_SHIFT:
               if (bit_tick)
               begin
                  bc_tx <= shift_reg[BC_FRAME_BITS-1];
                  shift_reg <= {shift_reg[BC_FRAME_BITS-2:0], 1'b0};
                  if (bit_idx_reg == 5'h00)
                     bc_state_reg <= BC_LOAD;
                  else
                     bit_idx_reg <= bit_idx_reg - 1'b1;
               end
         endcase
      end
   end

   // Checks
   sequence s_cfg_access(logic [1:0] sel);
      is_cfg && port_select_reg == sel;
   endsequence
   sequence s_quiet_then_tick;
      !bit_tick [*3] ##1 bit_tick;
   endsequence
   property p_bc_rate_hi;
      @(posedge link_clk) disable iff (link_rst)
      (rate_hi_reg && bit_tick) |=> s_quiet_then_tick;
   endproperty
   a_bc_rate_hi: assert property (p_bc_rate_hi)
      else $error("High back-channel rate bit period wrong");
   property p_frame_gpio;
      @(posedge link_clk) disable iff (link_rst)
      bc_state_reg == BC_LOAD |=>
         shift_reg.gpio == $past(s2l_2_reg[4:1]);
   endproperty
   a_frame_gpio: assert property (p_frame_gpio)
      else $error("Frame pin field not sampled state");
   property p_read_port1;
      @(posedge clock) disable iff (rst)
      (reg_read && !reg_write) ##0 s_cfg_access(2'b11) |=>
         reg_rvalid && reg_rdata == cfg_reg[1][$past(cfg_idx)];
   endproperty
   a_read_port1: assert property (p_read_port1)
      else $error("Read with both selects not port 1 copy");
   property p_write_both;
      @(posedge clock) disable iff (rst)
      reg_write ##0 s_cfg_access(2'b11) |=>
         cfg_reg[0][$past(cfg_idx)] == $past(reg_wdata) &&
         cfg_reg[1][$past(cfg_idx)] == $past(reg_wdata);
   endproperty
   a_write_both: assert property (p_write_both)
      else $error("Write with both selects missed a copy");
   property p_pdb_float;
      @(posedge clock) disable iff (rst)
      !pdb_s |=> !lock_pin.oe && !pass_pin.oe && !data_oe &&
         !disp_clk_oe && gpio_first_pin.oe == 4'h0;
   endproperty
   a_pdb_float: assert property (p_pdb_float)
      else $error("Output driven while powered down");
   property p_irq_low;
      @(posedge clock) disable iff (rst)
      !pdb_s |=> irq_pin_oe && !irq_pin_o;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("Interrupt pin not pulled low in power-down");
   property p_lock_high;
      @(posedge clock) disable iff (rst)
      (pdb_s && out_en && sleep_sel && locked_s) |=>
         lock_pin.o && lock_pin.oe && data_oe;
   endproperty
   a_lock_high: assert property (p_lock_high)
      else $error("Lock not high after lock sequence");
   property p_osc_clock;
      @(posedge clock) disable iff (rst)
      (pdb_s && out_en && !sleep_sel && osc_en && !locked_s) |=>
         disp_clk_mode == CLK_OSC && disp_clk_oe;
   endproperty
   a_osc_clock: assert property (p_osc_clock)
      else $error("Oscillator clock not selected on lost input");
   property p_second_lane;
      @(posedge clock) disable iff (rst)
      !two_lane_s |=> gpio_second_pin.oe == 4'h0;
   endproperty
   a_second_lane: assert property (p_second_lane)
      else $error("Second-lane pin driven in one-lane mode");
endmodule // deser_status_port_gpio_ctrl

// ===== dv/serializer_model.sv
// Serializer side: decodes back-channel frames, models remote interrupt.
// Assumes each bit stands a whole number of link_clk cycles.
`timescale 1ns/1ps
module serializer_model
   import deser_ctrl_pkg::*;
(
   // Link
   input wire logic link_clk,
   input wire logic rst,
   input wire logic bc_tx,
   input wire logic bc_frame_start,
   // Far-side status
   input wire logic status_rd,
   output bc_frame_t rx_frame,
   output int frames,
   output int period,
   output logic remote_irq_out_n
);
   logic [479:0] hist;
   int cnt;
   logic irq_prev;
   // First sample of each bit, counted back from the next load
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt <= 0;
         frames <= 0;
         period <= 0;
      end
      else
      begin
         hist <= {hist[478:0], bc_tx};
         cnt <= bc_frame_start ? 0 : cnt + 1;
         if (bc_frame_start)
         begin
            period <= cnt + 1;
            frames <= frames + 1;
            for (int j = 0; j < 29; j++)
               rx_frame[j] <= hist[j * (period / 29)];
         end
      end
   end
   // Falls on a new interrupt, released by a status read
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
      begin
         irq_prev <= 1'b0;
         remote_irq_out_n <= 1'b1;
      end
      else
      begin
         irq_prev <= rx_frame.irq;
         if (rx_frame.irq && !irq_prev)
            remote_irq_out_n <= 1'b0;
         else if (status_rd)
            remote_irq_out_n <= 1'b1;
      end
   end
endmodule // serializer_model

// ===== dv/deser_status_port_gpio_ctrl_tb.sv
// Bench: register calls, output matrix, pins, back channel, interrupt.
// Assumes the design package and the serializer model are compiled first.
`timescale 1ns/1ps
module deser_status_port_gpio_ctrl_tb;
   import deser_ctrl_pkg::*;
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
   err_count++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
   localparam logic [7:0] OC_TAB [7] = '{8'h00, 8'h10, 8'h80, 8'ha0,
      8'h90, 8'h80, 8'h10};
   localparam logic [7:0] ST_TAB [7] = '{8'h5c, 8'h40, 8'h5c, 8'h5f,
      8'hfd, 8'h5c, 8'hc0};
   logic clock = 0, link_clk = 0, rst = 1, reg_write = 0, reg_read = 0;
   logic power_down_bar = 0, back_channel_rate_strap = 1, serial_active = 0;
   logic two_lane_mode = 0, fwd_color18 = 0, bist_pass_in = 1;
   logic downstream_irq_in = 1, status_rd = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [7:0] bc_ctrl_data = 8'h3c, bc_cp_data = 8'ha5;
   logic [3:0] fwd_gpio_first = 4'h0, fwd_gpio_second = 4'h0;
   logic [3:0] gpio_first_in = 4'he, gpio_second_in = 4'h0;
   logic [31:0] rx_data = 32'h5a5ac3c3, data_o;
   logic [7:0] reg_rdata, st;
   logic reg_rvalid, bc_tx, bc_frame_start, data_oe, disp_clk_oe;
   logic color_18bit_mode, irq_pin_o, irq_pin_oe, remote_irq_n;
   pin_drive_t lock_pin, pass_pin;
   clk_mode_t disp_clk_mode;
   gpio_drive_t gpio_first_pin, gpio_second_pin;
   bc_frame_t rx_frame;
   int frames, period, err_count = 0, total_checks = 0;
   // Undriven fields masked so floating outputs compare clean
   assign st = {lock_pin, pass_pin.o & pass_pin.oe, pass_pin.oe, data_oe,
      disp_clk_oe, disp_clk_mode & {2{disp_clk_oe}}};
   initial forever #12.5 clock = ~clock;
   initial
   begin
      #3;
      forever #6 link_clk = ~link_clk;
   end
   deser_status_port_gpio_ctrl #(.LOCK_CYCLES(4)) DUT (.clock, .rst,
      .link_clk, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .power_down_bar, .back_channel_rate_strap,
      .serial_active, .two_lane_mode, .fwd_color18, .fwd_gpio_first,
      .fwd_gpio_second, .bc_ctrl_data, .bc_cp_data, .bc_tx,
      .bc_frame_start, .rx_data, .bist_pass_in, .lock_pin, .pass_pin,
      .data_o, .data_oe, .disp_clk_mode, .disp_clk_oe, .color_18bit_mode,
      .gpio_first_in, .gpio_second_in, .gpio_first_pin, .gpio_second_pin,
      .downstream_irq_in, .irq_pin_o, .irq_pin_oe);
   serializer_model far_end (.link_clk, .rst, .bc_tx, .bc_frame_start,
      .status_rd, .rx_frame, .frames, .period,
      .remote_irq_out_n(remote_irq_n));
   function automatic logic [7:0] crc8(input logic [20:0] d);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 20; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
      return c;
   endfunction
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      settle(1);
      reg_write = 1;
      reg_addr = a;
      reg_wdata = v;
      settle(1);
      reg_write = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      settle(1);
      reg_read = 1;
      reg_addr = a;
      settle(1);
      reg_read = 0;
      `CHK(reg_rvalid, 1'b1)
      `CHK(reg_rdata, e)
   endtask
   task automatic wait_frames(input int n);
      int f;
      f = frames;
      for (int i = 0; i < 9000 && frames < f + n; i++) @(posedge clock);
      settle(1);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #1_000_000;
      err_count++;
      stop_test();
   end
   initial
   begin
      settle(10);
      rst = 0;
      rd(OUTPUT_CONTROL_ADDR, OUTPUT_CONTROL_RESET);
      rd(PIN0_CONFIG_ADDR, PIN_CONFIG_RESET);
      rd(8'h50, 8'h00);
      `CHK({lock_pin.oe, pass_pin.oe, data_oe, disp_clk_oe}, 4'h0)
      `CHK({gpio_first_pin.oe, gpio_second_pin.oe}, 8'h00)
      `CHK({irq_pin_oe, irq_pin_o}, 2'b10)
      wr(PORT_SELECT_ADDR, 8'hfd);
      rd(PORT_SELECT_ADDR, 8'h01);
      wr(PIN1_PIN2_CONFIG_ADDR, 8'h53);
      wr(PORT_SELECT_ADDR, 8'h02);
      wr(PIN1_PIN2_CONFIG_ADDR, 8'h35);
      wr(OUTPUT_CONTROL_ADDR, 8'h10);
      wr(PORT_SELECT_ADDR, 8'h03);
      rd(PIN1_PIN2_CONFIG_ADDR, 8'h35);
      wr(PIN0_CONFIG_ADDR, 8'h05);
      wr(PORT_SELECT_ADDR, 8'h00);
      wr(PIN0_CONFIG_ADDR, 8'h33);
      rd(PIN1_PIN2_CONFIG_ADDR, 8'h53);
      wr(PORT_SELECT_ADDR, 8'h02);
      rd(PIN0_CONFIG_ADDR, 8'h05);
      wr(PORT_SELECT_ADDR, 8'h01);
      rd(PIN0_CONFIG_ADDR, 8'h05);
      rd(OUTPUT_CONTROL_ADDR, 8'h10);
      power_down_bar = 1;
      for (int i = 0; i < 7; i++)
      begin
         wr(OUTPUT_CONTROL_ADDR, OC_TAB[i]);
         if (i == 4)
         begin
            @(posedge link_clk) #1 serial_active = 1;
            for (int k = 0; k < 80 && lock_pin.o !== 1'b1; k++)
               @(posedge clock);
         end
         settle(8);
         `CHK(st, ST_TAB[i])
         `CHK(data_o & {32{data_oe}}, (i == 4) ? rx_data : 32'h0)
         if (i == 0) `CHK(gpio_first_pin, 8'h0f)
      end
      wr(OUTPUT_CONTROL_ADDR, 8'h90);
      @(posedge link_clk) #1 serial_active = 0;
      settle(12);
      // Pass must keep its last valid value, not follow the input
      bist_pass_in = 0;
      settle(2);
      `CHK(st, 8'h7c)
      @(posedge link_clk) #1 serial_active = 1;
      fwd_gpio_first = 4'b1101;
      fwd_gpio_second = 4'b0011;
      fwd_color18 = 1;
      settle(60);
      `CHK(gpio_first_pin.oe, 4'b0101)
      `CHK(gpio_first_pin.o & 4'b0101, 4'b0101)
      `CHK(gpio_second_pin.oe, 4'b0000)
      `CHK(color_18bit_mode, 1'b1)
      @(posedge link_clk) #1 two_lane_mode = 1;
      settle(8);
      `CHK(gpio_second_pin, 8'h33)
      downstream_irq_in = 0;
      wait_frames(3);
      `CHK(rx_frame[28:13], 16'h3ca5)
      `CHK(rx_frame[12:8], 5'h05)
      `CHK(rx_frame.crc, crc8({20'h3ca52, 1'b1}))
      `CHK(period / 29, BC_DIV_HIGH)
      `CHK(remote_irq_n, 1'b0)
      status_rd = 1;
      settle(1);
      status_rd = 0;
      downstream_irq_in = 1;
      wait_frames(3);
      `CHK({remote_irq_n, rx_frame.irq}, 2'b10)
      back_channel_rate_strap = 0;
      rst = 1;
      settle(10);
      rst = 0;
      wait_frames(3);
      `CHK(period / 29, BC_DIV_LOW)
      stop_test();
   end
endmodule // deser_status_port_gpio_ctrl_tb
